//--- capture_timer.sv
// Sixteen-bit capture/compare timer with a byte-wide CPU register port.
// Assumes one CPU access per cycle; read data appears on the cycle after the strobe.
`timescale 1ns/1ps

module capture_timer
  import capture_timer_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  // CPU register port
  input  wire logic [3:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Debug
  input  wire logic       debug_halt,
  // Event input
  input  wire logic       event_raw,
  // Results
  output logic            capture_irq_req,
  output logic            waveform_out
);

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  logic           enable;
  counter_mode_t  counter_mode_select;
  logic           event_edge;
  logic           event_input_enable;
  logic           irq_enable;
  logic           irq_flag;
  logic           debug_keep_running;
  logic [7:0]     wide_access_latch;
  logic [15:0]    count_value;
  logic [15:0]    capture_compare_value;
  logic           gate_run;
  freq_pw_state_t fp_state;

  logic [15:0]    next_cnt;
  logic           next_gate;
  freq_pw_state_t next_fp;
  logic           set_flag;
  logic           cap_load;

  timer_event_if evt ();

  event_sync u_sync (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .event_raw (event_raw),
    .evt       (evt)
  );

  // Register decode.
  wire wr_control   = clk_en & reg_wr & (reg_addr == OFS_CONTROL);
  wire wr_mode      = clk_en & reg_wr & (reg_addr == OFS_MODE);
  wire wr_event     = clk_en & reg_wr & (reg_addr == OFS_EVENT_CONTROL);
  wire wr_irq_en    = clk_en & reg_wr & (reg_addr == OFS_IRQ_ENABLE);
  wire wr_flags     = clk_en & reg_wr & (reg_addr == OFS_IRQ_FLAGS);
  wire wr_debug     = clk_en & reg_wr & (reg_addr == OFS_DEBUG_HALT);
  wire wr_latch     = clk_en & reg_wr & (reg_addr == OFS_WIDE_LATCH);
  wire wr_cnt_lo    = clk_en & reg_wr & (reg_addr == OFS_COUNT_LO);
  wire wr_cnt_hi    = clk_en & reg_wr & (reg_addr == OFS_COUNT_HI);
  wire wr_cmp_lo    = clk_en & reg_wr & (reg_addr == OFS_COMPARE_LO);
  wire wr_cmp_hi    = clk_en & reg_wr & (reg_addr == OFS_COMPARE_HI);
  wire rd_cnt_lo    = clk_en & reg_rd & (reg_addr == OFS_COUNT_LO);
  wire rd_cmp_lo    = clk_en & reg_rd & (reg_addr == OFS_COMPARE_LO);

  wire cnt_commit   = wr_cnt_lo;
  wire cmp_commit   = wr_cmp_lo;

  // Mode classes.
  wire mode_top     = (counter_mode_select == MODE_PERIODIC) |
                      (counter_mode_select == MODE_TIMEOUT)  |
                      (counter_mode_select == MODE_SINGLE);
  wire mode_capture = (counter_mode_select == MODE_CAPTURE)     |
                      (counter_mode_select == MODE_FREQ)        |
                      (counter_mode_select == MODE_PULSE_WIDTH) |
                      (counter_mode_select == MODE_FREQ_PW);
  wire mode_gated   = (counter_mode_select == MODE_TIMEOUT) |
                      (counter_mode_select == MODE_SINGLE)  |
                      (counter_mode_select == MODE_FREQ_PW);

  wire halted       = debug_halt & ~debug_keep_running;
  wire evt_ok       = event_input_enable & enable & ~halted;
  wire evt_sel      = evt_ok & (event_edge ? evt.fall : evt.rise);
  wire evt_opp      = evt_ok & (event_edge ? evt.rise : evt.fall);
  wire single_start = evt_ok & (event_edge ? (evt.rise | evt.fall) : evt.rise);
  wire counting     = enable & ~halted & (mode_gated ? gate_run : 1'b1);
  wire top_hit      = (count_value == capture_compare_value);
  wire pwm_hit      = (count_value[7:0] == capture_compare_value[7:0]);
  wire [15:0] count_inc = count_value + 16'h0001;

  // Counter sequencing per mode.
  always_comb
  begin
    next_cnt  = counting ? count_inc : count_value;
    next_gate = gate_run;
    next_fp   = fp_state;
    set_flag  = 1'b0;
    cap_load  = 1'b0;
    unique case (counter_mode_select)
      MODE_PERIODIC, MODE_TIMEOUT, MODE_SINGLE:
      begin
        if (counting && top_hit)
        begin
          set_flag = 1'b1;
          next_cnt = RESET_WORD;
          if (counter_mode_select == MODE_SINGLE)
            next_gate = 1'b0;
        end
        if (counter_mode_select == MODE_TIMEOUT)
        begin
          if (evt_sel)
            next_gate = 1'b1;
          else if (evt_opp)
            next_gate = 1'b0;
        end
        if (counter_mode_select == MODE_SINGLE && !gate_run && single_start)
          next_gate = 1'b1;
      end
      MODE_CAPTURE:
      begin
        if (evt_sel)
        begin
          cap_load = 1'b1;
          set_flag = 1'b1;
        end
      end
      MODE_FREQ:
      begin
        if (evt_sel)
        begin
          cap_load = 1'b1;
          set_flag = 1'b1;
          next_cnt = RESET_WORD;
        end
      end
      MODE_PULSE_WIDTH:
      begin
        if (evt_sel)
          next_cnt = RESET_WORD;
        else if (evt_opp)
        begin
          cap_load = 1'b1;
          set_flag = 1'b1;
        end
      end
      MODE_FREQ_PW:
      begin
        unique case (fp_state)
          FP_IDLE:
          begin
            if (evt_sel)
            begin
              next_cnt  = RESET_WORD;
              next_gate = 1'b1;
              next_fp   = FP_HIGH;
            end
          end
          FP_HIGH:
          begin
            if (evt_opp)
            begin
              cap_load = 1'b1;
              next_fp  = FP_LOW;
            end
          end
          FP_LOW:
          begin
            if (evt_sel)
            begin
              set_flag  = 1'b1;
              next_gate = 1'b0;
              next_fp   = FP_IDLE;
            end
          end
          default:
            next_fp = FP_IDLE;
        endcase
      end
      MODE_PWM8:
      begin
        if (counting && pwm_hit)
        begin
          set_flag = 1'b1;
          next_cnt = RESET_WORD;
        end
      end
    endcase
  end

  // Flag: a set in the same cycle as a clear wins.
  wire flag_clear = (wr_flags & reg_wdata[BIT_CAPTURE_IRQ]) | (rd_cmp_lo & mode_capture);
  wire next_flag  = set_flag | (irq_flag & ~flag_clear);

  // Shared byte latch for wide accesses.
  wire latch_load = wr_latch | wr_cnt_hi | wr_cmp_hi;
  wire [7:0] next_latch = latch_load ? reg_wdata :
                          rd_cnt_lo  ? count_value[15:8] :
                          rd_cmp_lo  ? capture_compare_value[15:8] :
                                       wide_access_latch;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      enable                <= 1'b0;
      counter_mode_select   <= MODE_PERIODIC;
      event_edge            <= 1'b0;
      event_input_enable    <= 1'b0;
      irq_enable            <= 1'b0;
      irq_flag              <= 1'b0;
      debug_keep_running    <= 1'b0;
      wide_access_latch     <= RESET_BYTE;
      count_value           <= RESET_WORD;
      capture_compare_value <= RESET_WORD;
      gate_run              <= 1'b0;
      fp_state              <= FP_IDLE;
    end
    else if (clk_en)
    begin
      if (wr_control)
        enable <= reg_wdata[BIT_ENABLE];
      if (wr_mode)
        counter_mode_select <= counter_mode_t'(reg_wdata[2:0]);
      if (wr_event)
      begin
        event_edge         <= reg_wdata[BIT_EVENT_EDGE];
        event_input_enable <= reg_wdata[BIT_EVENT_INPUT_EN];
      end
      if (wr_irq_en)
        irq_enable <= reg_wdata[BIT_CAPTURE_IRQ];
      if (wr_debug)
        debug_keep_running <= reg_wdata[BIT_KEEP_RUNNING];
      irq_flag          <= next_flag;
      wide_access_latch <= next_latch;
      gate_run          <= next_gate;
      fp_state          <= next_fp;
      // Software writes to the count and compare words override any internal update in the same cycle.
      count_value <= cnt_commit ? {wide_access_latch, reg_wdata} : next_cnt;
      if (cmp_commit)
        capture_compare_value <= {wide_access_latch, reg_wdata};
      else if (cap_load)
        capture_compare_value <= count_value;
    end
  end

  // Read data; high bytes come back from the shared latch.
  logic [7:0] read_mux;
  always_comb
  begin
    read_mux = RESET_BYTE;
    unique case (reg_addr)
      OFS_CONTROL:       read_mux = {7'h00, enable};
      OFS_MODE:          read_mux = {5'h00, counter_mode_select};
      OFS_EVENT_CONTROL: read_mux = {3'h0, event_edge, 3'h0, event_input_enable};
      OFS_IRQ_ENABLE:    read_mux = {7'h00, irq_enable};
      OFS_IRQ_FLAGS:     read_mux = {7'h00, irq_flag};
      OFS_RUN_STATUS:    read_mux = {7'h00, counting};
      OFS_DEBUG_HALT:    read_mux = {7'h00, debug_keep_running};
      OFS_WIDE_LATCH:    read_mux = wide_access_latch;
      OFS_COUNT_LO:      read_mux = count_value[7:0];
      OFS_COMPARE_LO:    read_mux = capture_compare_value[7:0];
      OFS_COUNT_HI,
      OFS_COMPARE_HI:    read_mux = wide_access_latch;
      default:           read_mux = RESET_BYTE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      reg_rdata <= RESET_BYTE;
    else if (clk_en && reg_rd)
      reg_rdata <= read_mux;
  end

  assign capture_irq_req = irq_flag & irq_enable;

  waveform_gen #(
    .PERIOD_WIDTH (8)
  ) u_wave (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .active    (enable & (counter_mode_select == MODE_PWM8)),
    .count_low (count_value[7:0]),
    .duty      (capture_compare_value[15:8]),
    .wave      (waveform_out)
  );

  sequence s_cnt_hi_write;
    clk_en && reg_wr && reg_addr == OFS_COUNT_HI;
  endsequence

  sequence s_cnt_lo_write;
    clk_en && reg_wr && reg_addr == OFS_COUNT_LO;
  endsequence

  // A gap between the two halves is legal as long as nothing touches the shared latch in it.
  sequence s_latch_quiet;
    !latch_load && !rd_cnt_lo && !rd_cmp_lo;
  endsequence

  sequence s_fp_second_edge;
    clk_en && counter_mode_select == MODE_FREQ_PW && fp_state == FP_LOW && evt_sel;
  endsequence

  a_irq_gate_enabled: assert property (
    clk_en && set_flag && irq_enable && !wr_irq_en |=> capture_irq_req)
    else $error("capture request missing after flag set with enable");

  a_flag_w1c_clear: assert property (
    clk_en && !set_flag && (flag_clear) |=> !irq_flag)
    else $error("capture flag not cleared");

  a_top_match_flag: assert property (
    clk_en && counting && mode_top && top_hit && !cnt_commit |=> irq_flag && count_value == 16'h0000)
    else $error("top match did not flag and wrap");

  a_freq_restart: assert property (
    clk_en && counter_mode_select == MODE_FREQ && evt_sel && !cnt_commit && !cmp_commit
    |=> irq_flag && count_value == 16'h0000 && capture_compare_value == $past(count_value))
    else $error("frequency capture wrong");

  a_capture_keep: assert property (
    clk_en && counter_mode_select == MODE_CAPTURE && evt_sel && !cnt_commit && !cmp_commit
    |=> capture_compare_value == $past(count_value) && count_value == $past(count_inc))
    else $error("event capture disturbed count or lost value");

  a_pw_capture: assert property (
    clk_en && counter_mode_select == MODE_PULSE_WIDTH && evt_opp && !cmp_commit
    |=> irq_flag && capture_compare_value == $past(count_value))
    else $error("pulse-width capture wrong");

  a_fp_stop: assert property (
    s_fp_second_edge |=> irq_flag && !gate_run && fp_state == FP_IDLE)
    else $error("second edge did not stop counter");

  a_pwm_wrap: assert property (
    clk_en && counter_mode_select == MODE_PWM8 && counting && pwm_hit && !cnt_commit
    |=> irq_flag && count_value == 16'h0000)
    else $error("pwm period match wrong");

  a_halt_freeze: assert property (
    clk_en && halted && !cnt_commit |=> count_value == $past(count_value))
    else $error("count moved during debug halt");

  a_wide_commit: assert property (
    s_cnt_hi_write ##1 s_latch_quiet ##1 s_cnt_lo_write
    |=> count_value == {$past(reg_wdata, 3), $past(reg_wdata)})
    else $error("wide write did not commit both bytes");

  a_status_read: assert property (
    clk_en && reg_rd && reg_addr == OFS_RUN_STATUS |=> reg_rdata == {7'h00, $past(counting)})
    else $error("run status read wrong");

endmodule : capture_timer

//--- capture_timer_pkg.sv
// Shared constants and types for the capture timer: register offsets, field positions,
// reset values and the counter mode and sequencing enumerations.
// Assumes a byte-wide CPU register port with four address bits.

package capture_timer_pkg;

  localparam logic [3:0] OFS_CONTROL        = 4'h0;
  localparam logic [3:0] OFS_MODE           = 4'h1;
  localparam logic [3:0] OFS_EVENT_CONTROL  = 4'h4;
  localparam logic [3:0] OFS_IRQ_ENABLE     = 4'h5;
  localparam logic [3:0] OFS_IRQ_FLAGS      = 4'h6;
  localparam logic [3:0] OFS_RUN_STATUS     = 4'h7;
  localparam logic [3:0] OFS_DEBUG_HALT     = 4'h8;
  localparam logic [3:0] OFS_WIDE_LATCH     = 4'h9;
  localparam logic [3:0] OFS_COUNT_LO       = 4'hA;
  localparam logic [3:0] OFS_COUNT_HI       = 4'hB;
  localparam logic [3:0] OFS_COMPARE_LO     = 4'hC;
  localparam logic [3:0] OFS_COMPARE_HI     = 4'hD;

  localparam int BIT_ENABLE         = 0;
  localparam int BIT_EVENT_INPUT_EN = 0;
  localparam int BIT_EVENT_EDGE     = 4;
  localparam int BIT_CAPTURE_IRQ    = 0;
  localparam int BIT_RUN            = 0;
  localparam int BIT_KEEP_RUNNING   = 0;

  localparam logic [7:0]  RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  typedef enum logic [2:0] {
    MODE_PERIODIC    = 3'b000,
    MODE_TIMEOUT     = 3'b001,
    MODE_CAPTURE     = 3'b010,
    MODE_FREQ        = 3'b011,
    MODE_PULSE_WIDTH = 3'b100,
    MODE_FREQ_PW     = 3'b101,
    MODE_SINGLE      = 3'b110,
    MODE_PWM8        = 3'b111
  } counter_mode_t;

  typedef enum logic [1:0] {
    FP_IDLE = 2'b00,
    FP_HIGH = 2'b01,
    FP_LOW  = 2'b10
  } freq_pw_state_t;

endpackage : capture_timer_pkg

//--- event_source.sv
// Far-side model of the capture timer: the peripheral event line.
// Assumes the bench calls drive() from its single stimulus thread.
`timescale 1ns/1ps

module event_source
(
  // Clock
  input  wire logic core_clk,
  // Event line
  output logic      event_raw
);
  initial event_raw = 1'b0;

  // Each level is held for a fixed span so that two edges never merge in the synchroniser.
  task automatic drive(input logic level, input int hold);
    @(posedge core_clk);
    event_raw <= level;
    repeat (hold) @(posedge core_clk);
  endtask : drive
endmodule : event_source

//--- event_sync.sv
// Synchroniser and edge detector for the asynchronous event input.
// Assumes event_raw is unrelated to core_clk.
`timescale 1ns/1ps

module event_sync
(
  // Clock, reset, enable
  input  wire logic   core_clk,
  input  wire logic   rst_n,
  input  wire logic   clk_en,
  // Raw event
  input  wire logic   event_raw,
  // Qualified edges
  timer_event_if.src  evt
);

  logic [2:0] sync;
  logic       level;
  wire        agree = (sync[1] == sync[2]);

  // A change is accepted only once the second and third stages agree.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sync  <= 3'h0;
      level <= 1'b0;
    end
    else if (clk_en)
    begin
      sync  <= {sync[1:0], event_raw};
      if (agree)
        level <= sync[2];
    end
  end

  assign evt.rise = clk_en & agree & sync[2] & ~level;
  assign evt.fall = clk_en & agree & ~sync[2] & level;

endmodule : event_sync

//--- tb.sv
// Self-checking bench for the capture timer, driving its byte register port and event line.
// Assumes the design package and the event source model are compiled first.
`timescale 1ns/1ps

module tb import capture_timer_pkg::*;;
  logic        core_clk, rst_n, clk_en, reg_wr, reg_rd, debug_halt;
  logic        event_raw, capture_irq_req, waveform_out;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rv;
  logic [15:0] wa, wb;
  int          num_errors, n_tests, hi;

  capture_timer capture_timer_inst (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .debug_halt(debug_halt), .event_raw(event_raw),
    .capture_irq_req(capture_irq_req), .waveform_out(waveform_out));

  event_source event_source_inst (.core_clk(core_clk), .event_raw(event_raw));

  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic in_range(input logic [15:0] seen, input logic [15:0] lo, input logic [15:0] top,
                          input string what);
    check({15'h0000, (seen >= lo) && (seen <= top)}, 16'h0001, what);
  endtask : in_range

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // The low byte goes first on reads and last on writes, so the shared latch pairs them.
  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    logic [7:0] lo;
    logic [7:0] hb;
    rd(a, lo);
    rd(a + 4'h1, hb);
    v = {hb, lo};
  endtask : rd16

  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr(a + 4'h1, v[15:8]);
    wr(a, v[7:0]);
  endtask : wr16

  task automatic wait_irq();
    int n;
    n = 0;
    while (capture_irq_req !== 1'b1 && n < 300)
    begin
      @(posedge core_clk);
      n++;
    end
    #1;
    check({15'h0000, capture_irq_req}, 16'h0001, "irq");
  endtask : wait_irq

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    complete_run();
  end

  initial
  begin
    rst_n      = 1'b0;
    clk_en     = 1'b1;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    reg_addr   = 4'h0;
    reg_wdata  = 8'h00;
    debug_halt = 1'b0;
    num_errors = 0;
    n_tests    = 0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;

    for (int a = 5; a < 16; a++)
    begin
      rd(a[3:0], rv);
      check({8'h00, rv}, 16'h0000, "reset");
    end
    wr(OFS_WIDE_LATCH, 8'hA5);
    rd(OFS_WIDE_LATCH, rv);
    check({8'h00, rv}, 16'h00A5, "latch");
    wr(OFS_COMPARE_HI, 8'h3C);
    rd16(OFS_COMPARE_LO, wa);
    check(wa, 16'h0000, "high alone");
    wr16(OFS_COMPARE_LO, 16'h3C5A);
    rd16(OFS_COMPARE_LO, wa);
    check(wa, 16'h3C5A, "compare word");
    rd(OFS_WIDE_LATCH, rv);
    check({8'h00, rv}, 16'h003C, "shared latch");
    for (int m = 0; m < 8; m++)
    begin
      wr(OFS_MODE, m[7:0]);
      rd(OFS_MODE, rv);
      check({13'h0000, rv[2:0]}, m[15:0], "mode");
    end
    wr(OFS_MODE, 8'h00);
    end_test("registers");

    wr16(OFS_COMPARE_LO, 16'h0010);
    wr(OFS_IRQ_ENABLE, 8'h01);
    wr(OFS_CONTROL, 8'h01);
    rd(OFS_RUN_STATUS, rv);
    check({8'h00, rv}, 16'h0001, "running");
    wait_irq();
    rd16(OFS_COUNT_LO, wa);
    in_range(wa, 16'h0000, 16'h0010, "top wrap");
    wr(OFS_IRQ_ENABLE, 8'h00);
    check({15'h0000, capture_irq_req}, 16'h0000, "masked");
    rd(OFS_IRQ_FLAGS, rv);
    check({8'h00, rv}, 16'h0001, "flag kept");
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_RUN_STATUS, 8'h01);
    rd(OFS_RUN_STATUS, rv);
    check({8'h00, rv}, 16'h0000, "stopped");
    wr(OFS_IRQ_FLAGS, 8'h01);
    rd(OFS_IRQ_FLAGS, rv);
    check({8'h00, rv}, 16'h0000, "w1c");
    end_test("periodic");

    wr16(OFS_COMPARE_LO, 16'hFFFF);
    wr(OFS_CONTROL, 8'h01);
    wr16(OFS_COUNT_LO, 16'h8000);
    wr(OFS_CONTROL, 8'h00);
    rd16(OFS_COUNT_LO, wa);
    in_range(wa, 16'h8000, 16'h8004, "count write");
    wr(OFS_CONTROL, 8'h01);
    @(posedge core_clk);
    debug_halt <= 1'b1;
    rd16(OFS_COUNT_LO, wa);
    rd16(OFS_COUNT_LO, wb);
    check(wb, wa, "halted");
    wr(OFS_DEBUG_HALT, 8'h01);
    rd16(OFS_COUNT_LO, wa);
    rd16(OFS_COUNT_LO, wb);
    in_range(wb - wa, 16'h0003, 16'h0005, "keep running");
    @(posedge core_clk);
    debug_halt <= 1'b0;
    wr(OFS_DEBUG_HALT, 8'h00);
    end_test("debug");

    wr(OFS_EVENT_CONTROL, 8'h01);
    wr(OFS_MODE, 8'h02);
    event_source_inst.drive(1'b1, 8);
    rd(OFS_IRQ_FLAGS, rv);
    check({8'h00, rv}, 16'h0001, "capture flag");
    rd16(OFS_COMPARE_LO, wa);
    in_range(wa, 16'h0001, 16'hFFF0, "captured");
    rd(OFS_IRQ_FLAGS, rv);
    check({8'h00, rv}, 16'h0000, "read clear");
    rd16(OFS_COUNT_LO, wb);
    in_range(wb - wa, 16'h0001, 16'h0028, "keeps count");
    event_source_inst.drive(1'b0, 8);
    wr(OFS_EVENT_CONTROL, 8'h00);
    event_source_inst.drive(1'b1, 8);
    rd(OFS_IRQ_FLAGS, rv);
    check({8'h00, rv}, 16'h0000, "events off");
    event_source_inst.drive(1'b0, 8);
    end_test("capture");

    wr(OFS_EVENT_CONTROL, 8'h01);
    wr(OFS_MODE, 8'h03);
    event_source_inst.drive(1'b1, 8);
    event_source_inst.drive(1'b0, 8);
    event_source_inst.drive(1'b1, 8);
    rd(OFS_IRQ_FLAGS, rv);
    check({8'h00, rv}, 16'h0001, "freq flag");
    rd16(OFS_COMPARE_LO, wa);
    in_range(wa, 16'h0010, 16'h0014, "period");
    rd16(OFS_COUNT_LO, wb);
    in_range(wb, 16'h0000, 16'h0014, "restart");
    event_source_inst.drive(1'b0, 8);
    wr(OFS_MODE, 8'h04);
    event_source_inst.drive(1'b1, 8);
    event_source_inst.drive(1'b0, 8);
    rd(OFS_IRQ_FLAGS, rv);
    check({8'h00, rv}, 16'h0001, "width flag");
    rd16(OFS_COMPARE_LO, wa);
    in_range(wa, 16'h0007, 16'h000B, "width");
    wr(OFS_MODE, 8'h05);
    event_source_inst.drive(1'b1, 8);
    event_source_inst.drive(1'b0, 8);
    event_source_inst.drive(1'b1, 8);
    rd(OFS_IRQ_FLAGS, rv);
    check({8'h00, rv}, 16'h0001, "second edge");
    rd(OFS_RUN_STATUS, rv);
    check({8'h00, rv}, 16'h0000, "stopped");
    rd16(OFS_COUNT_LO, wa);
    rd16(OFS_COUNT_LO, wb);
    check(wb, wa, "frozen");
    event_source_inst.drive(1'b0, 8);
    end_test("measure");

    // Time-out: the selected edge starts, the opposite stops; then single-shot runs once to TOP.
    wr(OFS_IRQ_FLAGS, 8'h01);
    wr16(OFS_COUNT_LO, 16'h0000);
    wr16(OFS_COMPARE_LO, 16'h0040);
    wr(OFS_MODE, 8'h01);
    rd(OFS_RUN_STATUS, rv);
    check({8'h00, rv}, 16'h0000, "timeout idle");
    event_source_inst.drive(1'b1, 8);
    rd(OFS_RUN_STATUS, rv);
    check({8'h00, rv}, 16'h0001, "timeout started");
    event_source_inst.drive(1'b0, 8);
    rd16(OFS_COUNT_LO, wa);
    in_range(wa, 16'h0009, 16'h000D, "timeout window");
    rd(OFS_IRQ_FLAGS, rv);
    check({8'h00, rv}, 16'h0000, "below top");
    event_source_inst.drive(1'b1, 8);
    repeat (60) @(posedge core_clk);
    rd(OFS_IRQ_FLAGS, rv);
    check({8'h00, rv}, 16'h0001, "timeout top");
    event_source_inst.drive(1'b0, 8);
    wr(OFS_IRQ_FLAGS, 8'h01);
    wr16(OFS_COUNT_LO, 16'h0000);
    wr(OFS_MODE, 8'h06);
    event_source_inst.drive(1'b1, 8);
    rd(OFS_RUN_STATUS, rv);
    check({8'h00, rv}, 16'h0001, "single started");
    repeat (80) @(posedge core_clk);
    rd(OFS_RUN_STATUS, rv);
    check({8'h00, rv}, 16'h0000, "single stopped");
    rd(OFS_IRQ_FLAGS, rv);
    check({8'h00, rv}, 16'h0001, "single top");
    rd16(OFS_COUNT_LO, wa);
    check(wa, 16'h0000, "single rest");
    event_source_inst.drive(1'b0, 8);
    end_test("gated");

    wr(OFS_CONTROL, 8'h00);
    wr(OFS_EVENT_CONTROL, 8'h00);
    wr16(OFS_COUNT_LO, 16'h0000);
    wr16(OFS_COMPARE_LO, 16'h0409);
    wr(OFS_IRQ_FLAGS, 8'h01);
    wr(OFS_IRQ_ENABLE, 8'h01);
    wr(OFS_MODE, 8'h07);
    wr(OFS_CONTROL, 8'h01);
    wait_irq();
    hi = 0;
    repeat (20)
    begin
      @(posedge core_clk);
      #1;
      if (waveform_out === 1'b1)
        hi++;
    end
    check(hi[15:0], 16'h0008, "duty");
    end_test("pwm");
    complete_run();
  end
endmodule : tb

//--- timer_event_if.sv
// Interface carrying the qualified edges of the external event input.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps

interface timer_event_if;
  logic rise;
  logic fall;
  modport src (output rise, output fall);
  modport dst (input rise, input fall);
endinterface : timer_event_if

//--- waveform_gen.sv
// Eight-bit PWM waveform stage: output high while the count is below the duty byte.
// Assumes the caller resets the count at the period match.
`timescale 1ns/1ps

module waveform_gen #(
  parameter int PERIOD_WIDTH = 8
)
(
  // Clock, reset, enable
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire logic                    clk_en,
  // Waveform control
  input  wire logic                    active,
  input  wire logic [PERIOD_WIDTH-1:0] count_low,
  input  wire logic [PERIOD_WIDTH-1:0] duty,
  // Output
  output logic                         wave
);

  if (PERIOD_WIDTH < 1 || PERIOD_WIDTH > 16)
  begin : g_width_check
    $error("waveform_gen: PERIOD_WIDTH out of range");
  end

  wire below_duty = (count_low < duty);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      wave <= 1'b0;
    else if (clk_en)
      wave <= active & below_duty;
  end

endmodule : waveform_gen
